// ### core/vcs_defs.svh
// Purpose: Constants of the common-voltage command registers
// Assumes: Included by bare name
// Notes:   Definitions only
`ifndef VCS_DEFS_SVH
`define VCS_DEFS_SVH

// ----------------------------------------
// Command decode
// ----------------------------------------
`define VCS_CMD_CODE 8'hc5

// ----------------------------------------
// Field positions
// ----------------------------------------
`define VCS_FLAG_BIT 0
`define VCS_SEL_BIT 7

// ----------------------------------------
// Reset values
// ----------------------------------------
`define VCS_FLAG_RST 1'b0
`define VCS_FACTOR_RST 8'h40
`define VCS_SEL_RST 1'b0
`define VCS_STORED_RST 8'h40
`define VCS_PIN_IDLE 11'h300

// ----------------------------------------
// Factor code map, ratio in 1/64 steps
// ----------------------------------------
`define VCS_CODE_MAX 8'h7f
`define VCS_CODE_ZERO 8'h80
`define VCS_CODE_HALT 8'hff
`define VCS_RATIO_FULL 8'h80

`endif

// ### core/vcs_pkg.sv
// Purpose: Types of the common-voltage command registers
// Assumes: Nothing
// Notes:   Constants live in vcs_defs.svh
package vcs_pkg;

   // ----------------------------------------
   // Parameter sequence
   // ----------------------------------------
   typedef enum logic [2:0] {
      st_idle = 3'h0,
      st_p1 = 3'h1,
      st_p2 = 3'h3,
      st_p3 = 3'h2,
      st_p4 = 3'h6
   } vcs_state_t;

   // ----------------------------------------
   // Carriers
   // ----------------------------------------
   typedef struct packed {
      logic command_data_select;
      logic read_strobe_n;
      logic write_strobe_n;
      logic [7:0] data;
   } vcs_bus_t;

   typedef struct packed {
      logic halt;
      logic inhibit;
      logic [7:0] ratio_mag;
   } vcs_vcom_t;

endpackage : vcs_pkg

// ### core/vcs_sync.sv
// Purpose: Two-stage synchroniser for pin inputs
// Assumes: Single clock mclk
// Notes:   First stage is read only by the second
`timescale 1ns/1ps
module vcs_sync #(
   parameter int W = 1,
   parameter logic [W-1:0] INIT = '0
) (
   input logic mclk,           // System clock
   input logic rst,            // Synchronous reset
   input logic [W-1:0] din,    // Asynchronous input
   output logic [W-1:0] dout   // Synchronised output
);
   logic [W-1:0] s1_q, s1_d;
   logic [W-1:0] s2_q, s2_d;

   always_comb begin
      s1_d = din;
      s2_d = s1_q;
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         s1_q <= INIT;
         s2_q <= INIT;
      end else begin
         s1_q <= s1_d;
         s2_q <= s2_d;
      end
   end

   assign dout = s2_q;
endmodule : vcs_sync

// ### core/vcs_ratio.sv
// Purpose: Maps the active factor code to a common-voltage ratio
// Assumes: Ratio magnitude is in 1/64 of the negative reference
// Notes:   Output is registered
`timescale 1ns/1ps
`include "vcs_defs.svh"
module vcs_ratio
   import vcs_pkg::*;
(
   input logic mclk,          // System clock
   input logic rst,           // Synchronous reset
   input logic [7:0] code,    // Active factor code
   output vcs_vcom_t vcom     // Ratio and stop flags
);
   vcs_vcom_t vcom_q, vcom_d;

   // ----------------------------------------
   // Linear map: code 00h gives -2, 7Fh gives -1/64
   // ----------------------------------------
   always_comb begin
      vcom_d = '0;
      if (code <= `VCS_CODE_MAX) begin
         vcom_d.ratio_mag = `VCS_RATIO_FULL - code; // [RL6]
      end else if (code == `VCS_CODE_HALT) begin
         vcom_d.halt = 1'b1;
      end else if (code != `VCS_CODE_ZERO) begin
         // Prohibited codes stop the output rather than guess a level
         vcom_d.inhibit = 1'b1; // [RL13]
         vcom_d.halt = 1'b1;
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         vcom_q <= '0;
      end else begin
         vcom_q <= vcom_d;
      end
   end

   assign vcom = vcom_q;

   AST_RATIO_LINEAR: assert property ( // [RL6]
      @(posedge mclk) disable iff (rst)
      (code <= `VCS_CODE_MAX) |=> (vcom.ratio_mag == 8'h80 - $past(code)) && !vcom.halt)
      else $error("ratio does not follow factor code");

   AST_RATIO_HALT: assert property ( // [RL6]
      @(posedge mclk) disable iff (rst)
      (code == `VCS_CODE_HALT) |=> vcom.halt && (vcom.ratio_mag == 8'h00))
      else $error("halt code did not stop output");
endmodule : vcs_ratio

// ### core/vcs_top.sv
// Purpose: Common-voltage command registers behind the display command bus
// Assumes: Bus pins are asynchronous to mclk; nv inputs are on mclk
// Notes:   Analog generator and nv programming lie outside
//
// What this block does
// RL1 - Code C5h written as a command opens the four-parameter sequence.
// RL2 - The first parameter reads the programmed flag in bit 0, other bits zero.
// RL3 - The programmed flag is set by the device itself, never by the host.
// RL4 - The flag reads 0 while nv memory is blank and 1 once programmed; here a reset clears it to 0 even after programming.
// RL5 - The second parameter writes the 8-bit factor code, reset 40h.
// RL6 - The factor code steps linearly from -2 at 00h to -1/64 at 7Fh.
// RL7 - The device derives the ratio from the negative reference.
// RL8 - The third parameter stores data bit 7 as the source select bit.
// RL9 - Select 0 takes the nv value, select 1 the written factor code.
// RL10 - The fourth parameter reads the stored nv value, reset 40h.
// RL11 - That read shows the nv value, never the written factor code.
// RL12 - The command works in every display and power state.
// RL13 - The host never writes codes 81h to FEh and writes FFh only to halt.
`timescale 1ns/1ps
`include "vcs_defs.svh"
module vcs_top
   import vcs_pkg::*;
(
   input logic mclk,                  // 100 MHz system clock
   input logic rst,                   // Synchronous reset, active high
   input vcs_bus_t bus_pins,          // Command bus pins, asynchronous
   output logic [7:0] bus_dout,       // Read data to the bus
   output logic bus_doe_n,            // Low while driving the bus
   input logic nv_prog_done,          // Pulse: nv memory programmed
   input logic [7:0] nv_value,        // Value being programmed
   output logic [7:0] factor_code,    // Written factor code
   output logic source_select,        // Source select bit
   output logic programmed_flag,      // Nv memory programmed
   output vcs_vcom_t vcom             // Ratio to the voltage generator
);

   // ----------------------------------------
   // Pin synchronisation and strobe edges
   // ----------------------------------------
   vcs_bus_t bus_s;
   logic rd_prev_q, rd_prev_d;
   logic wr_prev_q, wr_prev_d;
   logic wr_rise;
   logic rd_fall;
   logic rd_rise;
   logic cmd_wr;
   logic par_wr;
   logic par_rd;

   vcs_sync #(
      .W(11),
      .INIT(`VCS_PIN_IDLE)
   ) u_sync (
      .mclk(mclk),
      .rst(rst),
      .din(bus_pins),
      .dout(bus_s)
   );

   always_comb begin
      rd_prev_d = bus_s.read_strobe_n;
      wr_prev_d = bus_s.write_strobe_n;
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         rd_prev_q <= 1'b1;
         wr_prev_q <= 1'b1;
      end else begin
         rd_prev_q <= rd_prev_d;
         wr_prev_q <= wr_prev_d;
      end
   end

   // Data is sampled with the strobe, so setup equals hold of the pins
   assign wr_rise = bus_s.write_strobe_n & ~wr_prev_q;
   assign rd_fall = ~bus_s.read_strobe_n & rd_prev_q;
   assign rd_rise = bus_s.read_strobe_n & ~rd_prev_q;
   assign cmd_wr = wr_rise & ~bus_s.command_data_select;
   assign par_wr = wr_rise & bus_s.command_data_select;
   assign par_rd = bus_s.command_data_select;

   // ----------------------------------------
   // Parameter sequence
   // ----------------------------------------
   vcs_state_t state_q, state_d;

   // No power-state input gates this machine, so sleep does not block it
   always_comb begin
      state_d = state_q; // [RL12]
      if (cmd_wr) begin
         if (bus_s.data == `VCS_CMD_CODE) begin
            state_d = st_p1; // [RL1]
         end else begin
            state_d = st_idle;
         end
      end else begin
         case (state_q)
            st_p1: begin
               if (rd_rise && par_rd) begin
                  state_d = st_p2;
               end
            end
            st_p2: begin
               if (par_wr) begin
                  state_d = st_p3;
               end
            end
            st_p3: begin
               if (par_wr) begin
                  state_d = st_p4;
               end
            end
            st_p4: begin
               if (rd_rise && par_rd) begin
                  state_d = st_idle;
               end
            end
            default: begin
               state_d = st_idle;
            end
         endcase
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         state_q <= st_idle;
      end else begin
         state_q <= state_d;
      end
   end

   // ----------------------------------------
   // Registers
   // ----------------------------------------
   logic flag_q, flag_d;
   logic [7:0] factor_q, factor_d;
   logic sel_q, sel_d;
   logic [7:0] stored_q, stored_d;

   always_comb begin
      flag_d = flag_q;
      factor_d = factor_q;
      sel_d = sel_q;
      stored_d = stored_q;
      // Only the nv side sets the flag; no bus path reaches it
      if (nv_prog_done) begin
         flag_d = 1'b1; // [RL3] [RL4]
         stored_d = nv_value; // [RL11]
      end
      if (par_wr && state_q == st_p2) begin
         factor_d = bus_s.data; // [RL5]
      end
      if (par_wr && state_q == st_p3) begin
         sel_d = bus_s.data[`VCS_SEL_BIT]; // [RL8]
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         flag_q <= `VCS_FLAG_RST;
         factor_q <= `VCS_FACTOR_RST;
         sel_q <= `VCS_SEL_RST;
         stored_q <= `VCS_STORED_RST;
      end else begin
         flag_q <= flag_d;
         factor_q <= factor_d;
         sel_q <= sel_d;
         stored_q <= stored_d;
      end
   end

   // ----------------------------------------
   // Read path
   // ----------------------------------------
   logic [7:0] dout_q, dout_d;
   logic doe_n_q, doe_n_d;

   always_comb begin
      dout_d = dout_q;
      doe_n_d = doe_n_q;
      if (rd_fall && par_rd && state_q == st_p1) begin
         dout_d = 8'h00;
         dout_d[`VCS_FLAG_BIT] = flag_q; // [RL2]
         doe_n_d = 1'b0;
      end else if (rd_fall && par_rd && state_q == st_p4) begin
         dout_d = stored_q; // [RL10] [RL11]
         doe_n_d = 1'b0;
      end else if (rd_rise) begin
         doe_n_d = 1'b1;
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         dout_q <= 8'h00;
         doe_n_q <= 1'b1;
      end else begin
         dout_q <= dout_d;
         doe_n_q <= doe_n_d;
      end
   end

   // ----------------------------------------
   // Voltage source selection
   // ----------------------------------------
   logic [7:0] active_code;

   assign active_code = sel_q ? factor_q : stored_q; // [RL9]

   vcs_ratio u_ratio (
      .mclk(mclk),
      .rst(rst),
      .code(active_code), // [RL7]
      .vcom(vcom)
   );

   assign bus_dout = dout_q;
   assign bus_doe_n = doe_n_q;
   assign factor_code = factor_q;
   assign source_select = sel_q;
   assign programmed_flag = flag_q;

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);

   AST_CMD_OPENS: assert property ( // [RL1]
      cmd_wr && bus_s.data == 8'hc5 |=> state_q == st_p1 ##0 state_q != st_idle)
      else $error("command code did not open sequence");

   AST_FLAG_READ: assert property ( // [RL2]
      rd_fall && par_rd && state_q == st_p1 && !cmd_wr
      |=> bus_dout == {7'h00, $past(flag_q)} && !bus_doe_n)
      else $error("first parameter read data wrong");

   AST_FLAG_SET: assert property ( // [RL3]
      nv_prog_done |=> programmed_flag ##1 programmed_flag)
      else $error("programmed flag not set by nv");

   AST_FLAG_CAUSE: assert property ( // [RL4]
      $rose(programmed_flag) |-> $past(nv_prog_done))
      else $error("programmed flag rose without nv event");

   AST_FACTOR_WRITE: assert property ( // [RL5]
      par_wr && state_q == st_p2 && !nv_prog_done
      |=> factor_code == $past(bus_s.data) && state_q == st_p3)
      else $error("factor code not stored");

   AST_SEL_WRITE: assert property ( // [RL8]
      par_wr && state_q == st_p3 |=> source_select == $past(bus_s.data[7]))
      else $error("source select not stored");

   AST_SOURCE_NV: assert property ( // [RL9]
      !sel_q && stored_q <= 8'h7f && $stable(stored_q)
      |=> vcom.ratio_mag == 8'h80 - $past(stored_q))
      else $error("nv source not used");

   AST_STORED_READ: assert property ( // [RL10]
      rd_fall && par_rd && state_q == st_p4 && !cmd_wr
      |=> bus_dout == $past(stored_q) ##1 bus_doe_n == $past(rd_rise))
      else $error("fourth parameter read data wrong");

   AST_STORED_KEPT: assert property ( // [RL11]
      par_wr && !nv_prog_done |=> $stable(stored_q))
      else $error("bus write changed stored value");

   AST_RATIO_SOURCE: assert property ( // [RL7]
      sel_q && factor_q <= 8'h7f && $stable(factor_q) && $stable(sel_q)
      |=> vcom.ratio_mag == 8'h80 - $past(factor_q))
      else $error("ratio not from factor code");

   AST_DOE_RELEASE: assert property ( // [RL10]
      rd_rise |=> bus_doe_n)
      else $error("bus drive not released after read strobe");

   AST_OTHER_CMD: assert property ( // [RL1]
      cmd_wr && bus_s.data != 8'hc5 |=> state_q == st_idle)
      else $error("foreign command did not close sequence");

   // Parameter writes outside an open sequence must leave the factor code and select bit alone
   AST_IDLE_IGNORED: assert property ( // [RL1]
      par_wr && state_q == st_idle
      |=> $stable(factor_code) && $stable(source_select))
      else $error("parameter write in idle changed a register");

   COV_FULL_SEQ: cover property (
      state_q == st_p4 && rd_rise && par_rd);

   COV_HALT: cover property (
      vcom.halt && sel_q);

   COV_SEL_SET: cover property (
      $rose(sel_q));

   COV_NV_READ: cover property (
      rd_fall && state_q == st_p4 && flag_q);

   COV_INHIBIT: cover property (
      vcom.inhibit && sel_q);

endmodule : vcs_top

// ### dv/vcs_host.sv
// Purpose: Host model on the command bus pins
// Assumes: Pins change at the falling edge of mclk
// Notes:   Each strobe level is held at least 4 cycles so the two-flop sync sees it; the released data byte is held 2
`timescale 1ns/1ps
`include "vcs_defs.svh"
module vcs_host
   import vcs_pkg::*;
(
   input logic mclk,           // System clock
   output vcs_bus_t bus_pins,  // Pins driven by the host
   input logic [7:0] bus_dout, // Read data from the device
   input logic bus_doe_n       // Device drive enable
);
   initial begin
      bus_pins = `VCS_PIN_IDLE;
   end

   task automatic hold(input int n);
      repeat (n) @(negedge mclk);
   endtask : hold

   // ----------------------------------------
   // Strobed write, command when dc is low
   // ----------------------------------------
   task automatic put(input logic dc, input logic [7:0] d);
      bus_pins.command_data_select = dc;
      bus_pins.data = d;
      hold(4);
      bus_pins.write_strobe_n = 1'b0;
      hold(4);
      bus_pins.write_strobe_n = 1'b1;
      hold(2);
      // Released lines must not keep showing the last byte; changed well after
      // the synced rise, and a step before any next call drives the data again
      bus_pins.data = ~d;
      hold(2);
   endtask : put

   // ----------------------------------------
   // Strobed read with dc high
   // ----------------------------------------
   task automatic get(output logic [7:0] d, output logic oe_n);
      bus_pins.command_data_select = 1'b1;
      bus_pins.data = ~bus_pins.data;
      hold(4);
      bus_pins.read_strobe_n = 1'b0;
      hold(6);
      @(posedge mclk);
      d = bus_dout;
      oe_n = bus_doe_n;
      @(negedge mclk);
      bus_pins.read_strobe_n = 1'b1;
      hold(4);
   endtask : get
endmodule : vcs_host

// ### dv/vcs_top_tb.sv
// Purpose: Self-checking bench of the common-voltage command registers
// Assumes: Host model drives the pins, bench drives the nv side
// Notes:   Expected ratios are worked out locally from the code map
`timescale 1ns/1ps
`include "vcs_defs.svh"
module vcs_top_tb;
   import vcs_pkg::*;
   logic mclk = 1'b0;
   logic rst = 1'b1;
   logic nv_prog_done = 1'b0;
   logic [7:0] nv_value = 8'h00;
   vcs_bus_t bus_pins;
   logic [7:0] bus_dout;
   logic bus_doe_n;
   logic [7:0] factor_code;
   logic source_select;
   logic programmed_flag;
   vcs_vcom_t vcom;
   vcs_vcom_t ev;
   int bad_count = 0;
   int n_tests = 0;
   logic [7:0] rd;
   logic oe_n;
   logic [7:0] codes [8] = '{8'h00, 8'h01, 8'h3f, 8'h7f, 8'h80, 8'h81, 8'hfe, 8'hff};

   always #5 mclk = ~mclk;

   vcs_host HOST (.mclk(mclk), .bus_pins(bus_pins), .bus_dout(bus_dout),
      .bus_doe_n(bus_doe_n));
   vcs_top DUT (.mclk(mclk), .rst(rst), .bus_pins(bus_pins), .bus_dout(bus_dout),
      .bus_doe_n(bus_doe_n), .nv_prog_done(nv_prog_done), .nv_value(nv_value),
      .factor_code(factor_code), .source_select(source_select),
      .programmed_flag(programmed_flag), .vcom(vcom));

   // ----------------------------------------
   // Checks and closing
   // ----------------------------------------
   task automatic chk_b(input string nm, input logic [7:0] e, input logic [7:0] g);
      n_tests++;
      if (g !== e) begin
         bad_count++;
         $display("MISMATCH %s exp %h got %h", nm, e, g);
      end
   endtask : chk_b

   task automatic rd_chk(input string nm, input logic [7:0] e);
      HOST.get(rd, oe_n);
      chk_b(nm, e, rd);
      chk_b("doe_n", 8'h00, {7'h0, oe_n});
   endtask : rd_chk

   function automatic vcs_vcom_t exp_v(input logic [7:0] c);
      vcs_vcom_t v;
      v = '0;
      if (c <= `VCS_CODE_MAX) begin
         v.ratio_mag = `VCS_RATIO_FULL - c;
      end else if (c == `VCS_CODE_HALT) begin
         v.halt = 1'b1;
      end else if (c != `VCS_CODE_ZERO) begin
         v.halt = 1'b1;
         v.inhibit = 1'b1;
      end
      return v;
   endfunction : exp_v

   task automatic test_done();
      $display("Checks %0d, mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : test_done

   initial begin
      repeat (20000) @(posedge mclk);
      bad_count++;
      $display("MISMATCH watchdog exp done got timeout");
      test_done();
   end

   // ----------------------------------------
   // Test sequence
   // ----------------------------------------
   initial begin
      repeat (20) @(posedge mclk);
      @(negedge mclk) rst = 1'b0;
      @(negedge mclk);
      chk_b("factor", 8'h40, factor_code);
      chk_b("select", 8'h00, {7'h0, source_select});
      chk_b("flag", 8'h00, {7'h0, programmed_flag});
      chk_b("doe_n", 8'h01, {7'h0, bus_doe_n});
      chk_b("vcom_mag", 8'h40, vcom.ratio_mag);
      // Parameters outside a sequence or after a foreign command are dropped
      HOST.put(1'b1, 8'h12);
      HOST.put(1'b0, 8'hc4);
      HOST.put(1'b1, 8'h13);
      chk_b("factor", 8'h40, factor_code);
      HOST.put(1'b0, `VCS_CMD_CODE);
      rd_chk("p1_flag", 8'h00);
      HOST.put(1'b1, 8'h00);
      HOST.put(1'b1, 8'h80);
      rd_chk("p4_stored", 8'h40);
      chk_b("factor", 8'h00, factor_code);
      chk_b("select", 8'h01, {7'h0, source_select});
      chk_b("vcom_mag", 8'h80, vcom.ratio_mag);
      HOST.put(1'b1, 8'h22);
      chk_b("factor", 8'h00, factor_code);
      // Code map; the last entry is an intended halt
      foreach (codes[i]) begin
         HOST.put(1'b0, `VCS_CMD_CODE);
         HOST.get(rd, oe_n);
         HOST.put(1'b1, codes[i]);
         ev = exp_v(codes[i]);
         chk_b("halt_inh", {6'h0, ev.halt, ev.inhibit}, {6'h0, vcom.halt, vcom.inhibit});
         if (!ev.halt || ev.inhibit) begin
            chk_b("vcom_mag", ev.ratio_mag, vcom.ratio_mag);
         end
      end
      @(negedge mclk);
      nv_value = 8'h23;
      nv_prog_done = 1'b1;
      @(negedge mclk);
      nv_prog_done = 1'b0;
      nv_value = 8'h00;
      @(negedge mclk);
      chk_b("flag", 8'h01, {7'h0, programmed_flag});
      HOST.put(1'b0, `VCS_CMD_CODE);
      rd_chk("p1_flag", 8'h01);
      HOST.put(1'b1, 8'h55);
      HOST.put(1'b1, 8'h7f);
      chk_b("select", 8'h00, {7'h0, source_select});
      chk_b("vcom_mag", 8'h5d, vcom.ratio_mag);
      rd_chk("p4_stored", 8'h23);
      chk_b("factor", 8'h55, factor_code);
      // Second reset in mid-run clears the sticky flag
      rst = 1'b1;
      repeat (2) @(negedge mclk);
      rst = 1'b0;
      @(negedge mclk);
      chk_b("flag", 8'h00, {7'h0, programmed_flag});
      chk_b("factor", 8'h40, factor_code);
      test_done();
   end
endmodule : vcs_top_tb
